// *** tb/remote_node.sv ***
// Remote serial node: shared bit timing and a break generator on the line.
// Assumes one clock; the line idles at mark level, low when inv is set.
`timescale 1ns/1ps
module remote_node #(
  parameter int unsigned BIT_CYC = 8
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       nrst,
  // Control from the bench
  input  wire logic       inv,
  input  wire logic       send,
  input  wire logic [3:0] nbits,
  // Line side
  output      logic       tick,
  output      logic       line,
  output      logic       busy
);
  int unsigned div_q;
  logic [3:0]  left_q;

  // Bit time pulse
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      div_q <= 0;
      tick  <= 1'b0;
    end else begin
      tick  <= (div_q == BIT_CYC - 1);
      div_q <= (div_q == BIT_CYC - 1) ? 0 : div_q + 1;
    end
  end

  // Break of nbits bit times, started on a bit boundary
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      busy   <= 1'b0;
      left_q <= 4'h0;
    end else if (tick && !busy && send) begin
      busy   <= 1'b1;
      left_q <= nbits;
    end else if (tick && busy) begin
      left_q <= left_q - 4'h1;
      busy   <= (left_q != 4'h1);
    end
  end

  // Space level is the inverse of idle
  assign line = ~(busy ^ inv);
endmodule

// *** tb/test_uart_break_edge_status.sv ***
// Bench for the second status byte: APB tasks, host pulses, remote node.
// Assumes the hand-over timing of the block and an 8-cycle bit time.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_uart_break_edge_status;
  import uart_s2_pkg::*;
  localparam uart_in_type P_START = '{start_detect: 1'b1, default: 1'b0};
  localparam uart_in_type P_IDLE  = '{idle_detect: 1'b1, default: 1'b0};
  localparam uart_in_type P_FULL  = '{rx_full_set: 1'b1, default: 1'b0};
  localparam uart_in_type P_FE    = '{fe_set: 1'b1, default: 1'b0};
  localparam uart_in_type P_FEFUL = '{fe_set: 1'b1, rx_full_set: 1'b1, default: 1'b0};
  logic        mclk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0]  pstrb, nbits;
  logic        rerr, inv, send, tick, line, busy, ce;
  uart_in_type  uin, uin_w;
  uart_out_type uout;
  int          bad_count, n_compared, c, n;

  uart_break_edge_status u_dut (.mclk(mclk), .nrst(nrst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .rx_pin(line),
    .uart_in(uin_w), .uart_out(uout));
  remote_node u_far (.mclk(mclk), .nrst(nrst), .inv(inv), .send(send), .nbits(nbits),
    .tick(tick), .line(line), .busy(busy));

  always_comb begin
    uin_w          = uin;
    uin_w.bit_tick = tick;
  end

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rdat    = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic pulse(input uart_in_type m);
    @(posedge mclk);
    uin <= uin | m;
    @(posedge mclk);
    uin <= uin & ~m;
    @(posedge mclk);
  endtask

  task automatic send_break(input logic [3:0] len);
    nbits <= len;
    send  <= 1'b1;
    do begin
      @(posedge mclk);
    end while (busy !== 1'b1);
    send <= 1'b0;
    repeat (6) @(posedge mclk);
    `CHK(uout.rx_data, 1'b0)
    do begin
      @(posedge mclk);
    end while (busy !== 1'b0);
    repeat (24) @(posedge mclk);
    `CHK(uout.rx_data, 1'b1)
  endtask

  initial begin
    repeat (30000) @(posedge mclk);
    bad_count++;
    report_and_stop();
  end

  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h1;
    uin = '0;
    inv = 1'b0;
    send = 1'b0;
    nbits = 4'h0;
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    apb(1'b0, S2_ADDR, 8'h00);
    `CHK(rdat, 32'h0)
    apb(1'b1, S2_ADDR, 8'hff);
    apb(1'b0, S2_ADDR, 8'h00);
    `CHK(rdat, 32'h1e)
    apb(1'b1, S2_ADDR, 8'h00);
    pstrb <= 4'h0;
    apb(1'b1, S2_ADDR, 8'h1e);
    pstrb <= 4'h1;
    apb(1'b1, 12'h018, 8'h1e);
    `CHK(rerr, 1'b1)
    apb(1'b0, 12'h018, 8'h00);
    `CHK({rerr, rdat}, 33'h100000000)
    apb(1'b0, S2_ADDR, 8'h00);
    `CHK(rdat, 32'h0)
    $display("test registers done");
    for (c = 0; c < 8; c++) begin
      uin.nine_bit      <= c[0];
      uin.two_stop_bits <= c[1];
      inv               <= c[2];
      apb(1'b1, S2_ADDR, {2'b11, 1'b0, c[2], 4'h2});
      repeat (16) @(posedge mclk);
      apb(1'b1, S2_ADDR, {2'b11, 1'b0, c[2], 4'h2});
      send_break(4'(10 + c[0] + c[1]));
      apb(1'b0, S2_ADDR, 8'h00);
      `CHK(rdat[7], 1'b0)
      send_break(4'(11 + c[0] + c[1]));
      apb(1'b0, S2_ADDR, 8'h00);
      `CHK(rdat[7:6], 2'b11)
      apb(1'b1, S2_ADDR, {3'b000, c[2], 4'h2});
      apb(1'b0, S2_ADDR, 8'h00);
      `CHK(rdat[7:6], 2'b11)
      apb(1'b1, S2_ADDR, {2'b11, 1'b0, c[2], 4'h2});
      apb(1'b0, S2_ADDR, 8'h00);
      `CHK(rdat[7:6], 2'b00)
    end
    $display("test break detect done");
    inv <= 1'b0;
    apb(1'b1, S2_ADDR, 8'hc6);
    pulse(P_FEFUL);
    `CHK({uout.fe_set, uout.rx_full_set}, 2'b00)
    apb(1'b1, S2_ADDR, 8'hc4);
    pulse(P_FEFUL);
    `CHK({uout.fe_set, uout.rx_full_set}, 2'b11)
    pulse(P_FE);
    `CHK(uout.fe_set, 1'b0)
    $display("test framing done");
    for (c = 0; c < 8; c++) begin
      uin.nine_bit      <= c[0];
      uin.two_stop_bits <= c[1];
      apb(1'b1, S2_ADDR, {5'h00, c[2], 2'b00});
      do begin
        @(posedge mclk);
      end while (tick !== 1'b1);
      uin.tx_break_req <= 1'b1;
      @(posedge mclk);
      uin.tx_break_req <= 1'b0;
      n = 0;
      repeat (160) begin
        @(posedge mclk);
        if (uout.tx_break_low === 1'b1 && tick === 1'b1) n++;
      end
      `CHK(n, (c[2] ? 13 : 10) + c[0] + c[1])
      `CHK(uout.tx_break_low, 1'b0)
    end
    $display("test break transmit done");
    apb(1'b1, S2_ADDR, 8'h00);
    pulse(P_START);
    apb(1'b0, S2_ADDR, 8'h00);
    `CHK(rdat[0], 1'b1)
    pulse(P_IDLE);
    `CHK(uout.idle_set, 1'b1)
    apb(1'b0, S2_ADDR, 8'h00);
    `CHK(rdat[0], 1'b0)
    pulse(P_IDLE);
    `CHK(uout.idle_set, 1'b0)
    pulse(P_FULL);
    uin.receiver_standby <= 1'b1;
    pulse(P_IDLE);
    `CHK(uout.idle_set, 1'b0)
    pulse(P_FULL);
    apb(1'b1, S2_ADDR, 8'h08);
    pulse(P_IDLE);
    `CHK(uout.idle_set, 1'b1)
    $display("test idle and active done");
    ce <= 1'b0;
    pulse(P_START);
    ce <= 1'b1;
    apb(1'b0, S2_ADDR, 8'h00);
    `CHK(rdat[0], 1'b0)
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    apb(1'b0, S2_ADDR, 8'h00);
    `CHK(rdat, 32'h0)
    $display("test enable and reset done");
    report_and_stop();
  end
endmodule

// *** verilog/bit_run_counter.sv ***
// Counts bit ticks up to a length and then holds.
// Assumes tick is a one-cycle pulse per bit time on the same clock.
`timescale 1ns/1ps
module bit_run_counter #(
  parameter int unsigned CNT_W = 4
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             nrst,
  input  wire logic             ce,
  // Count control
  input  wire logic             clear,
  input  wire logic             tick,
  input  wire logic [CNT_W-1:0] len,
  // Status
  output      logic             reached
);

  logic [CNT_W-1:0] count_q;

  if (CNT_W < 4) begin : g_width_check
    $error("bit_run_counter needs at least four count bits");
  end

  // Saturating count of ticks
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      count_q <= '0;
    end else if (ce) begin
      if (clear) begin
        count_q <= '0;
      end else if (tick && (count_q < len)) begin
        count_q <= count_q + 1'b1;
      end
    end
  end

  assign reached = (count_q >= len);

endmodule

// *** verilog/uart_break_edge_status.sv ***
// Second status and control byte of the UART with break and edge logic.
// Assumes the host UART supplies bit ticks and receiver events on mclk.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
module uart_break_edge_status
  import uart_s2_pkg::*;
(
  // Clock and reset
  input  wire logic                      mclk,
  input  wire logic                      nrst,
  input  wire logic                      ce,
  // APB slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  input  wire logic [3:0]                pstrb,
  output      logic                      pready,
  output      logic [31:0]               prdata,
  output      logic                      pslverr,
  // Serial pin
  input  wire logic                      rx_pin,
  // Host UART
  input  wire uart_s2_pkg::uart_in_type  uart_in,
  output      uart_s2_pkg::uart_out_type uart_out
);

  import uart_s2_pkg::*;

  logic         pready_q;
  logic [31:0]  prdata_q;
  logic         pslverr_q;
  logic         lbk_flag_q;
  logic         edge_flag_q;
  logic         rx_inv_q;
  logic         wake_idle_q;
  logic         long_brk_q;
  logic         lbk_en_q;
  logic         rx_active_q;
  logic         sync1_q;
  logic         sync2_q;
  logic         pin_prev_q;
  logic         det_prev_q;
  logic         idle_armed_q;
  logic         tx_active_q;
  uart_out_type out_q;
  uart_out_type out_d;
  logic         hit;
  logic         take;
  logic         done;
  logic         wr_s2;
  logic         rx_line;
  logic         edge_hit;
  logic         det_reached;
  logic         lbk_set;
  logic         tx_reached;
  logic [3:0]   det_len;
  logic [3:0]   tx_len;
  logic [7:0]   s2_value;

  // Bus decode
  assign hit   = (paddr == S2_ADDR);
  assign take  = psel && penable && !pready_q;
  assign done  = psel && penable && pready_q;
  assign wr_s2 = done && pwrite && hit && pstrb[0];

  assign s2_value = {lbk_flag_q, edge_flag_q, 1'b0, rx_inv_q,
                     wake_idle_q, long_brk_q, lbk_en_q, rx_active_q};

  // APB answer one cycle into the access phase
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      pready_q <= take;
      if (take) begin
        prdata_q  <= (hit && !pwrite) ? {24'h00_0000, s2_value} : 32'h0000_0000;
        pslverr_q <= !hit;
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rx_inv_q    <= S2_RESET[BIT_RX_INV];
      wake_idle_q <= S2_RESET[BIT_WAKE_IDLE];
      long_brk_q  <= S2_RESET[BIT_LONG_BRK];
      lbk_en_q    <= S2_RESET[BIT_LBK_EN];
    end else if (ce && wr_s2) begin
      rx_inv_q    <= pwdata[BIT_RX_INV];
      wake_idle_q <= pwdata[BIT_WAKE_IDLE];
      long_brk_q  <= pwdata[BIT_LONG_BRK];
      lbk_en_q    <= pwdata[BIT_LBK_EN];
    end
  end

  // Pin synchroniser
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sync1_q    <= SYNC_RESET;
      sync2_q    <= SYNC_RESET;
      pin_prev_q <= SYNC_RESET;
    end else if (ce) begin
      sync1_q    <= rx_pin;
      sync2_q    <= sync1_q;
      pin_prev_q <= sync2_q;
    end
  end

  assign rx_line = sync2_q ^ rx_inv_q;

  assign edge_hit = rx_inv_q ? (sync2_q && !pin_prev_q) : (!sync2_q && pin_prev_q);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      edge_flag_q <= S2_RESET[BIT_EDGE_FLAG];
    end else if (ce) begin
      if (edge_hit) begin
        edge_flag_q <= 1'b1;
      end else if (wr_s2 && pwdata[BIT_EDGE_FLAG]) begin
        edge_flag_q <= 1'b0;
      end
    end
  end

  assign det_len = break_len(RX_BRK_DET, uart_in.nine_bit, uart_in.two_stop_bits);

  bit_run_counter #(
    .CNT_W   (4)
  ) u_det_cnt (
    .mclk    (mclk),
    .nrst    (nrst),
    .ce      (ce),
    .clear   (rx_line || !lbk_en_q),
    .tick    (uart_in.bit_tick),
    .len     (det_len),
    .reached (det_reached)
  );

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      det_prev_q <= 1'b0;
    end else if (ce) begin
      det_prev_q <= det_reached;
    end
  end

  assign lbk_set = lbk_en_q && det_reached && !det_prev_q;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lbk_flag_q <= S2_RESET[BIT_LBK_FLAG];
    end else if (ce) begin
      if (lbk_set) begin
        lbk_flag_q <= 1'b1;
      end else if (wr_s2 && pwdata[BIT_LBK_FLAG]) begin
        lbk_flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rx_active_q <= S2_RESET[BIT_RX_ACTIVE];
    end else if (ce) begin
      if (uart_in.start_detect) begin
        rx_active_q <= 1'b1;
      end else if (uart_in.idle_detect) begin
        rx_active_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      idle_armed_q <= 1'b1;
    end else if (ce) begin
      if (uart_in.rx_full_set) begin
        idle_armed_q <= 1'b1;
      end else if (uart_in.idle_detect) begin
        idle_armed_q <= 1'b0;
      end
    end
  end

  assign tx_len = break_len(long_brk_q ? TX_BRK_LONG : TX_BRK_SHORT,
                            uart_in.nine_bit, uart_in.two_stop_bits);

  bit_run_counter #(
    .CNT_W   (4)
  ) u_tx_cnt (
    .mclk    (mclk),
    .nrst    (nrst),
    .ce      (ce),
    .clear   (!tx_active_q),
    .tick    (uart_in.bit_tick),
    .len     (tx_len),
    .reached (tx_reached)
  );

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tx_active_q <= 1'b0;
    end else if (ce) begin
      if (tx_active_q && tx_reached) begin
        tx_active_q <= 1'b0;
      end else if (uart_in.tx_break_req) begin
        tx_active_q <= 1'b1;
      end
    end
  end

  // Outputs to the host UART
  always_comb begin
    out_d              = '0;
    out_d.rx_data      = rx_line;
    out_d.tx_break_low = tx_active_q && !tx_reached;
    out_d.rx_full_set  = uart_in.rx_full_set && !lbk_en_q;
    out_d.fe_set       = uart_in.fe_set && uart_in.rx_full_set && !lbk_en_q;
    out_d.idle_set     = uart_in.idle_detect && idle_armed_q &&
                         (!uart_in.receiver_standby || wake_idle_q);
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      out_q <= '{rx_data: 1'b1, default: 1'b0};
    end else if (ce) begin
      out_q <= out_d;
    end
  end

  assign pready   = pready_q;
  assign prdata   = prdata_q;
  assign pslverr  = pslverr_q;
  assign uart_out = out_q;

  // Helper for break length checks
  logic [3:0] h_ticks_q;
  logic [3:0] h_len_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      h_ticks_q <= 4'h0;
      h_len_q   <= 4'h0;
    end else if (ce) begin
      if (!tx_active_q) begin
        h_ticks_q <= 4'h0;
        h_len_q   <= tx_len;
      end else if (uart_in.bit_tick && !tx_reached) begin
        h_ticks_q <= h_ticks_q + 4'h1;
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst || !ce);

  a_edge_flag_set: assert property (edge_hit |=> edge_flag_q)
    else $error("edge flag not set after active edge");
  a_edge_flag_hold: assert property (
    edge_flag_q && !(wr_s2 && pwdata[BIT_EDGE_FLAG]) |=> edge_flag_q)
    else $error("edge flag lost without written one");
  a_lbk_flag_clear: assert property (
    wr_s2 && pwdata[BIT_LBK_FLAG] && !lbk_set |=> !lbk_flag_q)
    else $error("break flag not cleared by written one");
  a_lbk_flag_set: assert property (
    lbk_en_q && det_reached && !det_prev_q |=> lbk_flag_q)
    else $error("break flag not set on detected break");
  a_reserved_zero: assert property (pready_q |-> !prdata_q[BIT_RESERVED])
    else $error("reserved bit read as one");
  a_inhibit_full: assert property (lbk_en_q |=> !out_q.rx_full_set && !out_q.fe_set)
    else $error("full or framing passed while break detect on");
  a_fe_with_full: assert property (out_q.fe_set |-> out_q.rx_full_set)
    else $error("framing error without receive full");
  a_idle_gate: assert property (
    uart_in.receiver_standby && !wake_idle_q |=> !out_q.idle_set)
    else $error("idle set in standby with wake idle off");
  a_active_flag: assert property (
    uart_in.start_detect |=> rx_active_q ##0 $past(uart_in.start_detect))
    else $error("active flag not set on start");
  a_inv_path: assert property (out_q.rx_data == $past(sync2_q ^ rx_inv_q))
    else $error("receive data not following inversion");
  a_tx_length: assert property (
    $fell(tx_active_q) |-> h_ticks_q == h_len_q)
    else $error("transmitted break length wrong");

  a_lbk_flag_hold: assert property (
    lbk_flag_q && !(wr_s2 && pwdata[BIT_LBK_FLAG]) |=> lbk_flag_q)
    else $error("break flag lost without written one");
  a_edge_flag_clear: assert property (
    wr_s2 && pwdata[BIT_EDGE_FLAG] && !edge_hit |=> !edge_flag_q)
    else $error("edge flag not cleared by written one");
  a_lbk_quiet: assert property (
    !lbk_en_q && !lbk_flag_q |=> !lbk_flag_q)
    else $error("break flag set while detection disabled");
  a_edge_quiet: assert property (
    !edge_hit && !edge_flag_q |=> !edge_flag_q)
    else $error("edge flag set without active edge");
  a_active_clear: assert property (
    uart_in.idle_detect && !uart_in.start_detect |=> !rx_active_q)
    else $error("active flag not cleared on idle");
  a_idle_once: assert property (
    uart_in.idle_detect && !idle_armed_q |=> !out_q.idle_set)
    else $error("idle set twice in one idle period");
  a_full_pass: assert property (
    !lbk_en_q && uart_in.rx_full_set |=> out_q.rx_full_set)
    else $error("receive full blocked with break detect off");
  a_fe_pass: assert property (
    !lbk_en_q && uart_in.fe_set && uart_in.rx_full_set |=> out_q.fe_set)
    else $error("framing error blocked with break detect off");
  a_tx_start: assert property (
    !tx_active_q && uart_in.tx_break_req |=> tx_active_q)
    else $error("break request not started");
  a_tx_low_idle: assert property (
    !tx_active_q |=> !out_q.tx_break_low)
    else $error("break driven while transmit idle");

  c_break_seen: cover property (lbk_set);
  c_long_break: cover property (long_brk_q && $fell(tx_active_q));
  c_inverted_edge: cover property (rx_inv_q && edge_hit);
  c_idle_wake: cover property (uart_in.receiver_standby && out_q.idle_set);
  c_framing_passed: cover property (out_q.fe_set);

endmodule

// *** verilog/uart_s2_pkg.sv ***
// Constants, field layout and carrier types for the second UART status byte.
// Assumes one clock, APB register access and a host UART on the same clock.
// Function
// - Break detected while enabled sets break flag
// - Break flag clears only on written one
// - Active receive edge sets edge flag
// - Edge flag clears only on written one
// - Reserved bit reads zero, ignores writes
// - Inversion applies to all receive processing
// - Standby idle sets idle only if enabled
// - Short break transmits 10, 11, 12 bits
// - Long break transmits 13, 14, 15 bits
// - Framing errors unaffected by long break select
// - Break detect enable blocks framing and full
// - Break recognised at 11, 12, 13 bits
// - Active flag on start, cleared on idle
// - Framing error rises together with full
// - Idle flag once per idle period
package uart_s2_pkg;

  // Register index and byte address
  localparam int unsigned S2_INDEX = 5;
  localparam logic [11:0] S2_ADDR  = 12'(S2_INDEX * 4);

  // Field positions
  localparam int unsigned BIT_LBK_FLAG  = 7;
  localparam int unsigned BIT_EDGE_FLAG = 6;
  localparam int unsigned BIT_RESERVED  = 5;
  localparam int unsigned BIT_RX_INV    = 4;
  localparam int unsigned BIT_WAKE_IDLE = 3;
  localparam int unsigned BIT_LONG_BRK  = 2;
  localparam int unsigned BIT_LBK_EN    = 1;
  localparam int unsigned BIT_RX_ACTIVE = 0;

  // Values after reset
  localparam logic [7:0] S2_RESET = 8'h00;
  localparam logic       SYNC_RESET = 1'b1;

  // Break lengths in bit times, base case of 8 data bits and one stop bit
  localparam logic [3:0] TX_BRK_SHORT = 4'ha;
  localparam logic [3:0] TX_BRK_LONG  = 4'hd;
  localparam logic [3:0] RX_BRK_DET   = 4'hb;

  // Signals from the host UART
  typedef struct packed {
    logic nine_bit;
    logic two_stop_bits;
    logic receiver_standby;
    logic bit_tick;
    logic start_detect;
    logic idle_detect;
    logic fe_set;
    logic rx_full_set;
    logic tx_break_req;
  } uart_in_type;

  // Signals to the host UART
  typedef struct packed {
    logic rx_data;
    logic fe_set;
    logic rx_full_set;
    logic idle_set;
    logic tx_break_low;
  } uart_out_type;

  // Break length for the current frame format
  function automatic logic [3:0] break_len(input logic [3:0] base, input logic nine,
                                           input logic two);
    break_len = base + {3'h0, nine} + {3'h0, two};
  endfunction

endpackage
